/* File: wmrs_defs.svh */
/*
   Timing figures, counts and link framing constants for the enable/reset sequencer.
   Assumes a 100 MHz core clock on both ends.
*/
`ifndef WMRS_DEFS_SVH
`define WMRS_DEFS_SVH

`define WMRS_CLK_PERIOD_NS   10
`define WMRS_EN_LOW_MIN_US   30
`define WMRS_POR_MAX_MS      1.3
`define WMRS_PLL_SETTLE_US   100
`define WMRS_XTAL_STABLE_CYC 18'h00040
`define WMRS_DIGITAL_PHASE_LOCKED_LOOP_LOCK_CYC   18'h00080
`define WMRS_SLOW_HALF       8'h04
`define WMRS_FAST_HALF       8'h01
`define WMRS_LAST_NIBBLE     4'h7
`define WMRS_STOP_SLOT       4'h9
`define WMRS_GAP_LAST        4'h7

`endif

/* File: wmrs_pkg.sv */
/*
   Types for both ends of the enable/reset sequencer.
   Assumes wmrs_defs.svh for all figures.
*/
package wmrs_pkg;

   typedef enum logic [4:0] {
      WMRS_D_POR  = 5'h01,
      WMRS_D_OFF  = 5'h02,
      WMRS_D_XTAL = 5'h04,
      WMRS_D_DIGITAL_PHASE_LOCKED_LOOP = 5'h08,
      WMRS_D_RUN  = 5'h10
   } wmrs_dstate_t;

   typedef enum logic [6:0] {
      WMRS_H_RST  = 7'h01,
      WMRS_H_POR  = 7'h02,
      WMRS_H_CMD  = 7'h04,
      WMRS_H_BUSY = 7'h08,
      WMRS_H_IDLE = 7'h10,
      WMRS_H_SEND = 7'h20,
      WMRS_H_GAP  = 7'h40
   } wmrs_hstate_t;

   typedef struct packed {
      logic         en_m;
      logic         en_s;
      logic [1:0]   tgl_m;
      logic [1:0]   tgl_s;
      logic [1:0]   tgl_d;
      wmrs_dstate_t state;
      logic [17:0]  cnt;
      logic         off_mode;
      logic         pwr;
      logic         digital_phase_locked_loop_en;
      logic         blk_rst_n;
      logic         full_speed;
      logic         pll_valid;
      logic [31:0]  pll_setting;
      logic [31:0]  fw_word;
      logic         fw_valid;
   } wmrs_core_t;

   typedef struct packed {
      logic [1:0]  lvl_m;
      logic [1:0]  lvl_s;
      logic        cmd_d;
      logic [1:0]  tgl;
      logic        rx_on;
      logic [3:0]  nib;
      logic [31:0] shift;
      logic [31:0] word;
      logic        busy_oe;
   } wmrs_link_t;

   typedef struct packed {
      wmrs_hstate_t state;
      logic [17:0]  cnt;
      logic [17:0]  scnt;
      logic [7:0]   div;
      logic         sclk;
      logic         fast;
      logic         fast_pend;
      logic         pll_sent;
      logic         dat0_m;
      logic         dat0_s;
      logic         en_n;
      logic         cmd_o;
      logic         cmd_oe;
      logic [3:0]   dat_o;
      logic [3:0]   dat_oe;
      logic [3:0]   nib;
      logic [31:0]  shift;
      logic         fw_ready;
      logic         link_ready;
   } wmrs_host_t;

endpackage

/* File: wmrs_link_if.sv */
/*
   Enable pin and 4-bit SD link between host and module; resolves the lines.
   Undriven command and data lines read high, as with pull-ups.
*/
interface wmrs_link_if;
   logic       module_enable_n;
   logic       sd_clk;
   logic       cmd_h_o;
   logic       cmd_h_oe;
   logic [3:0] dat_h_o;
   logic [3:0] dat_h_oe;
   logic [3:0] dat_d_o;
   logic [3:0] dat_d_oe;
   logic       cmd;
   logic [3:0] dat;

   assign cmd = cmd_h_oe ? cmd_h_o : 1'b1;

   for (genvar b = 0; b < 4; b++)
   begin : g_dat
      assign dat[b] = dat_h_oe[b] ? dat_h_o[b] : (dat_d_oe[b] ? dat_d_o[b] : 1'b1);
   end

   modport host (
      output module_enable_n, sd_clk, cmd_h_o, cmd_h_oe, dat_h_o, dat_h_oe,
      input  cmd, dat
   );
   modport dev (
      input  module_enable_n, sd_clk, cmd, dat,
      output dat_d_o, dat_d_oe
   );
endinterface

/* File: wmrs_dev_end.sv */
/*
   Module end: enable pin handling, power-on reset, off mode, crystal and PLL
   start-up, block reset release, and firmware word reception over the SD link.
   Assumes the host makes the link clock and keeps it running while busy.
*/
`include "wmrs_defs.svh"

module wmrs_dev_end #(
   parameter int unsigned POR_CYC =
      $rtoi(`WMRS_POR_MAX_MS * 1.0e6 / `WMRS_CLK_PERIOD_NS)
) (
   // Crystal clock and rail reset
   input  wire logic        i_core_clk,
   input  wire logic        i_rst_n,
   // Link to the host
   wmrs_link_if.dev         link,
   // Power and clock controls
   output logic             o_off_mode,
   output logic             o_mac_pwr,
   output logic             o_bb_pwr,
   output logic             o_soc_pwr,
   output logic             o_xtal_en,
   output logic             o_digital_phase_locked_loop_en,
   output logic             o_blk_rst_n,
   output logic             o_full_speed,
   // Downloaded firmware
   output logic             o_pll_valid,
   output logic [31:0]      o_pll_setting,
   output logic [31:0]      o_fw_word,
   output logic             o_fw_valid
);

   localparam logic [17:0] POR_LAST = 18'(POR_CYC - 1);

   localparam wmrs_pkg::wmrs_core_t CORE_RST = '{
      state    : wmrs_pkg::WMRS_D_POR,
      off_mode : 1'b1,
      default  : '0
   };

   wmrs_pkg::wmrs_core_t core;
   wmrs_pkg::wmrs_core_t next_core;
   wmrs_pkg::wmrs_link_t lnk;
   wmrs_pkg::wmrs_link_t next_lnk;
   logic [1:0]           evt;

   ////////////////////////////////////////////////////////////////////////////
   // Core domain sequencer

   always_comb
   begin
      next_core          = core;
      next_core.en_m     = link.module_enable_n;
      next_core.en_s     = core.en_m;
      next_core.tgl_m    = lnk.tgl;
      next_core.tgl_s    = core.tgl_m;
      next_core.tgl_d    = core.tgl_s;
      next_core.fw_valid = 1'b0;
      evt                = core.tgl_s ^ core.tgl_d;

      if (!core.en_s)
      begin
         // Any low sample restarts from the power-on reset
         next_core.state      = wmrs_pkg::WMRS_D_POR;
         next_core.cnt        = '0;
         next_core.full_speed = 1'b0;
         next_core.pll_valid  = 1'b0;
      end
      else
      begin
         case (core.state)
            wmrs_pkg::WMRS_D_POR:
            begin
               if (core.cnt == POR_LAST)
               begin
                  next_core.state = wmrs_pkg::WMRS_D_OFF;
                  next_core.cnt   = '0;
               end
               else
               begin
                  next_core.cnt = core.cnt + 18'h00001;
               end
            end
            wmrs_pkg::WMRS_D_OFF:
            begin
               // Wait for the first host command
               if (evt[0])
               begin
                  next_core.state = wmrs_pkg::WMRS_D_XTAL;
               end
            end
            wmrs_pkg::WMRS_D_XTAL:
            begin
               if (core.cnt == `WMRS_XTAL_STABLE_CYC - 18'h00001)
               begin
                  next_core.state = wmrs_pkg::WMRS_D_DIGITAL_PHASE_LOCKED_LOOP;
                  next_core.cnt   = '0;
               end
               else
               begin
                  next_core.cnt = core.cnt + 18'h00001;
               end
            end
            wmrs_pkg::WMRS_D_DIGITAL_PHASE_LOCKED_LOOP:
            begin
               if (core.cnt == `WMRS_DIGITAL_PHASE_LOCKED_LOOP_LOCK_CYC - 18'h00001)
               begin
                  next_core.state = wmrs_pkg::WMRS_D_RUN;
                  next_core.cnt   = '0;
               end
               else
               begin
                  next_core.cnt = core.cnt + 18'h00001;
               end
            end
            wmrs_pkg::WMRS_D_RUN:
            begin
               // A later command switches from crystal rate to full speed
               if (evt[0])
               begin
                  next_core.full_speed = 1'b1;
               end
               if (evt[1])
               begin
                  next_core.fw_word  = lnk.word;
                  next_core.fw_valid = 1'b1;
                  // First word at crystal rate carries the PLL setting
                  if (!core.full_speed && !core.pll_valid)
                  begin
                     next_core.pll_setting = lnk.word;
                     next_core.pll_valid   = 1'b1;
                  end
               end
            end
            default:
            begin
               next_core.state = wmrs_pkg::WMRS_D_POR;
               next_core.cnt   = '0;
            end
         endcase
      end

      // Off mode keeps blocks unpowered and in reset
      next_core.off_mode  = next_core.state inside
         {wmrs_pkg::WMRS_D_POR, wmrs_pkg::WMRS_D_OFF};
      next_core.pwr       = !next_core.off_mode;
      next_core.digital_phase_locked_loop_en   = next_core.state inside
         {wmrs_pkg::WMRS_D_DIGITAL_PHASE_LOCKED_LOOP, wmrs_pkg::WMRS_D_RUN};
      next_core.blk_rst_n = next_core.state == wmrs_pkg::WMRS_D_RUN;
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         core <= CORE_RST;
      end
      else
      begin
         core <= next_core;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link domain: command detect, busy, word receive

   always_comb
   begin
      next_lnk       = lnk;
      next_lnk.lvl_m = {core.state == wmrs_pkg::WMRS_D_RUN, core.en_s};
      next_lnk.lvl_s = lnk.lvl_m;
      next_lnk.cmd_d = link.cmd;
      // Busy on data line 0 until blocks leave reset
      next_lnk.busy_oe = lnk.lvl_s[0] && !lnk.lvl_s[1];

      if (lnk.cmd_d && !link.cmd && lnk.lvl_s[0])
      begin
         next_lnk.tgl[0] = ~lnk.tgl[0];
      end

      if (!lnk.lvl_s[1])
      begin
         next_lnk.rx_on = 1'b0;
         next_lnk.nib   = '0;
      end
      else if (!lnk.rx_on)
      begin
         if (link.dat == 4'h0)
         begin
            next_lnk.rx_on = 1'b1;
            next_lnk.nib   = '0;
         end
      end
      else
      begin
         next_lnk.shift = {lnk.shift[27:0], link.dat};
         next_lnk.nib   = lnk.nib + 4'h1;
         if (lnk.nib == `WMRS_LAST_NIBBLE)
         begin
            // Word held until the next one; the host gap covers the crossing
            next_lnk.word   = {lnk.shift[27:0], link.dat};
            next_lnk.tgl[1] = ~lnk.tgl[1];
            next_lnk.rx_on  = 1'b0;
         end
      end
   end

   // Clocked only by the host; busy release and command detect count on edges between frames
   always_ff @(posedge link.sd_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         lnk <= '0;
      end
      else
      begin
         lnk <= next_lnk;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign link.dat_d_o   = 4'h0;
   assign link.dat_d_oe  = {3'h0, lnk.busy_oe};
   assign o_off_mode     = core.off_mode;
   assign o_mac_pwr      = core.pwr;
   assign o_bb_pwr       = core.pwr;
   assign o_soc_pwr      = core.pwr;
   assign o_xtal_en      = core.pwr;
   assign o_digital_phase_locked_loop_en      = core.digital_phase_locked_loop_en;
   assign o_blk_rst_n    = core.blk_rst_n;
   assign o_full_speed   = core.full_speed;
   assign o_pll_valid    = core.pll_valid;
   assign o_pll_setting  = core.pll_setting;
   assign o_fw_word      = core.fw_word;
   assign o_fw_valid     = core.fw_valid;

endmodule

/* File: wmrs_host_end.sv */
/*
   Host end: drives the enable pin, makes the link clock by division,
   starts the module, waits out busy and sends firmware words in 4-bit frames.
   Assumes one 100 MHz clock; the link clock is derived, not a second domain.
*/
`include "wmrs_defs.svh"

module wmrs_host_end #(
   parameter int unsigned POR_WAIT_CYC =
      $rtoi($ceil(`WMRS_POR_MAX_MS * 1.0e6 / `WMRS_CLK_PERIOD_NS)),
   parameter int unsigned PLL_CYC =
      (`WMRS_PLL_SETTLE_US * 1000 + `WMRS_CLK_PERIOD_NS - 1) / `WMRS_CLK_PERIOD_NS
) (
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_rst_n,
   // Link to the module
   wmrs_link_if.host        link,
   // User side
   input  wire logic        i_boot,
   input  wire logic        i_fw_valid,
   input  wire logic [31:0] i_fw_word,
   output logic             o_fw_ready,
   output logic             o_link_ready,
   output logic             o_full_speed
);

   localparam int unsigned EN_LOW_CYC =
      (`WMRS_EN_LOW_MIN_US * 1000 + `WMRS_CLK_PERIOD_NS - 1) / `WMRS_CLK_PERIOD_NS;
   localparam logic [17:0] EN_LAST  = 18'(EN_LOW_CYC - 1);
   localparam logic [17:0] POR_LAST = 18'(POR_WAIT_CYC - 1);
   localparam logic [17:0] PLL_DONE = 18'(PLL_CYC);

   localparam wmrs_pkg::wmrs_host_t HOST_RST = '{
      state   : wmrs_pkg::WMRS_H_RST,
      default : '0
   };

   wmrs_pkg::wmrs_host_t h;
   wmrs_pkg::wmrs_host_t next_h;
   logic                 fall;
   logic                 tick;

   always_comb
   begin
      next_h        = h;
      next_h.dat0_m = link.dat[0];
      next_h.dat0_s = h.dat0_m;
      tick = h.div == ((h.fast ? `WMRS_FAST_HALF : `WMRS_SLOW_HALF) - 8'h01);
      fall = tick && h.sclk;
      // Link clock stays at or under 50 MHz
      if (tick)
      begin
         next_h.div  = '0;
         next_h.sclk = ~h.sclk;
      end
      else
      begin
         next_h.div = h.div + 8'h01;
      end
      // Settling counted only once the setting word and its gap are through
      if (h.pll_sent && !h.fast && h.state == wmrs_pkg::WMRS_H_IDLE && h.scnt != PLL_DONE)
      begin
         next_h.scnt = h.scnt + 18'h00001;
      end

      case (h.state)
         wmrs_pkg::WMRS_H_RST:
         begin
            next_h.en_n = 1'b0;
            next_h.cnt  = h.cnt + 18'h00001;
            if (h.cnt == EN_LAST)
            begin
               next_h.state = wmrs_pkg::WMRS_H_POR;
               next_h.cnt   = '0;
               next_h.en_n  = 1'b1;
            end
         end
         wmrs_pkg::WMRS_H_POR:
         begin
            next_h.cnt = h.cnt + 18'h00001;
            if (h.cnt == POR_LAST)
            begin
               next_h.state = wmrs_pkg::WMRS_H_CMD;
               next_h.nib   = '0;
            end
         end
         wmrs_pkg::WMRS_H_CMD:
         begin
            if (fall && h.nib == 4'h0)
            begin
               next_h.cmd_o  = 1'b0;
               next_h.cmd_oe = 1'b1;
               next_h.nib    = 4'h1;
            end
            else if (fall)
            begin
               next_h.cmd_oe     = 1'b0;
               next_h.nib        = '0;
               next_h.state      = wmrs_pkg::WMRS_H_BUSY;
               next_h.link_ready = 1'b0;
               if (h.fast_pend)
               begin
                  next_h.fast      = 1'b1;
                  next_h.fast_pend = 1'b0;
                  next_h.div       = '0;
                  next_h.sclk      = 1'b0;
               end
            end
         end
         wmrs_pkg::WMRS_H_BUSY:
         begin
            if (h.dat0_s)
            begin
               next_h.state      = wmrs_pkg::WMRS_H_IDLE;
               next_h.link_ready = 1'b1;
            end
         end
         wmrs_pkg::WMRS_H_IDLE:
         begin
            if (h.fw_ready && i_fw_valid)
            begin
               next_h.shift    = i_fw_word;
               next_h.nib      = '0;
               next_h.pll_sent = 1'b1;
               next_h.state    = wmrs_pkg::WMRS_H_SEND;
            end
            else if (h.pll_sent && !h.fast && h.scnt == PLL_DONE)
            begin
               next_h.fast_pend = 1'b1;
               next_h.state     = wmrs_pkg::WMRS_H_CMD;
            end
         end
         wmrs_pkg::WMRS_H_SEND:
         begin
            if (fall)
            begin
               next_h.nib = h.nib + 4'h1;
               if (h.nib == 4'h0)
               begin
                  next_h.dat_o  = 4'h0;
                  next_h.dat_oe = 4'hF;
               end
               else if (h.nib == `WMRS_STOP_SLOT)
               begin
                  next_h.dat_oe = 4'h0;
                  next_h.nib    = '0;
                  next_h.state  = wmrs_pkg::WMRS_H_GAP;
               end
               else
               begin
                  next_h.dat_o = h.shift[31:28];
                  next_h.shift = {h.shift[27:0], 4'h0};
               end
            end
         end
         wmrs_pkg::WMRS_H_GAP:
         begin
            // Gap lets the module move the word across its clocks
            if (fall)
            begin
               next_h.nib = h.nib + 4'h1;
               if (h.nib == `WMRS_GAP_LAST)
               begin
                  next_h.nib   = '0;
                  next_h.state = wmrs_pkg::WMRS_H_IDLE;
               end
            end
         end
         default:
         begin
            next_h.state = wmrs_pkg::WMRS_H_RST;
            next_h.cnt   = '0;
         end
      endcase

      if (i_boot)
      begin
         next_h = HOST_RST;
         // Toggle here so a restart never stretches a link clock half period
         next_h.sclk = ~h.sclk;
      end
      next_h.fw_ready = next_h.state == wmrs_pkg::WMRS_H_IDLE
         && !(next_h.pll_sent && !next_h.fast && next_h.scnt == PLL_DONE);
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         h <= HOST_RST;
      end
      else
      begin
         h <= next_h;
      end
   end

   assign link.module_enable_n = h.en_n;
   assign link.sd_clk          = h.sclk;
   assign link.cmd_h_o         = h.cmd_o;
   assign link.cmd_h_oe        = h.cmd_oe;
   assign link.dat_h_o         = h.dat_o;
   assign link.dat_h_oe        = h.dat_oe;
   assign o_fw_ready           = h.fw_ready;
   assign o_link_ready         = h.link_ready;
   assign o_full_speed         = h.fast;

endmodule

/* File: wmrs_link_props.sv */
/*
   Concurrent checks on the link between the host end and the module end.
   Assumes the bench instantiates it beside the link interface, fed by name.
*/
module wmrs_link_props (
   // Clocks and reset
   input  wire logic       i_core_clk,
   input  wire logic       i_rst_n,
   input  wire logic       sd_clk,
   // Link lines
   input  wire logic       module_enable_n,
   input  wire logic       cmd_h_oe,
   input  wire logic       cmd,
   input  wire logic [3:0] dat_h_o,
   input  wire logic [3:0] dat_h_oe,
   input  wire logic [3:0] dat_d_o,
   input  wire logic [3:0] dat_d_oe
);

   ////////////////////////////////////////////////////////////////////////////
   logic [11:0] low_cnt;
   logic [2:0]  hold_cnt;
   logic        clk_q;
   logic        clk_seen;

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         low_cnt  <= 12'h000;
         hold_cnt <= 3'h0;
         clk_q    <= 1'b0;
         clk_seen <= 1'b0;
      end
      else
      begin
         clk_q    <= sd_clk;
         // Time spent in reset is no half period
         if (sd_clk != clk_q)
            clk_seen <= 1'b1;
         hold_cnt <= (sd_clk != clk_q) ? 3'h0 : hold_cnt + 3'h1;
         // Saturates so a long hold cannot wrap
         if (module_enable_n)
            low_cnt <= 12'h000;
         else if (low_cnt != 12'hFFF)
            low_cnt <= low_cnt + 12'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // One cycle of slack for where the count starts
   a_enable_low_min: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(module_enable_n) |-> low_cnt >= 12'hBB7)
      else $error("enable released too early");

   a_off_drops_busy: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      $fell(module_enable_n) |-> ##[1:40] !dat_d_oe[0])
      else $error("busy kept while held off");

   a_on_shows_busy: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(module_enable_n) |-> ##[1:40] dat_d_oe[0])
      else $error("no busy after enable");

   a_busy_drives_low: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      dat_d_oe[0] |-> !dat_d_o[0] && dat_d_oe[3:1] == 3'h0)
      else $error("device drives wrong data lines");

   a_no_contention: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      !(dat_h_oe[0] && dat_d_oe[0]))
      else $error("both ends drive data line 0");

   a_cmd_when_on: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      cmd_h_oe |-> module_enable_n)
      else $error("command while module held off");

   a_link_clk_rate: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      clk_seen |-> hold_cnt < 3'h4)
      else $error("link clock half period too long");

   a_cmd_one_slot: assert property (
      @(posedge sd_clk) disable iff (!i_rst_n)
      $fell(cmd) |=> cmd)
      else $error("command low not one link period");

   a_frame_shape: assert property (
      @(posedge sd_clk) disable iff (!i_rst_n)
      $rose(dat_h_oe[0]) |-> (dat_h_o == 4'h0 && dat_h_oe == 4'hF)
      ##1 (dat_h_oe == 4'hF) [*8] ##1 (dat_h_oe == 4'h0))
      else $error("word frame shape wrong");

   c_enable: cover property (@(posedge i_core_clk) $rose(module_enable_n));
   c_busy_end: cover property (@(posedge i_core_clk) $fell(dat_d_oe[0]));
   c_frame: cover property (@(posedge sd_clk) $rose(dat_h_oe[0]));

endmodule

/* File: wmrs_bench.sv */
/*
   Bench joining host end and module end through the link interface.
   Assumes both ends run on one 100 MHz clock; the host makes the link clock.
*/
module wmrs_bench;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int unsigned PLL_CYC = 100;

   logic        i_core_clk, i_rst_n, i_boot, i_fw_valid;
   logic [31:0] i_fw_word;
   logic        o_fw_ready, o_link_ready, h_full;
   logic        off_mode, mac_pwr, bb_pwr, soc_pwr, xtal_en, digital_phase_locked_loop_en, blk_rst_n;
   logic        d_full, pll_valid, fw_valid;
   logic [6:0]  pwr_vec;
   logic [31:0] pll_setting, fw_word;
   logic [31:0] rx_q[$];
   logic [31:0] words[4];
   int          err_total, checks_done, cyc, t_cmd, t_xtal, t_digital_phase_locked_loop, t_run, t_pll, t_fs;

   ////////////////////////////////////////////////////////////////////////////
   wmrs_link_if link ();

   assign pwr_vec = {mac_pwr, bb_pwr, soc_pwr, xtal_en, digital_phase_locked_loop_en, blk_rst_n, off_mode};

   wmrs_dev_end #(.POR_CYC(200)) wmrs_dev_end_i (
      .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .link(link),
      .o_off_mode(off_mode), .o_mac_pwr(mac_pwr), .o_bb_pwr(bb_pwr),
      .o_soc_pwr(soc_pwr), .o_xtal_en(xtal_en), .o_digital_phase_locked_loop_en(digital_phase_locked_loop_en),
      .o_blk_rst_n(blk_rst_n), .o_full_speed(d_full), .o_pll_valid(pll_valid),
      .o_pll_setting(pll_setting), .o_fw_word(fw_word), .o_fw_valid(fw_valid));

   wmrs_host_end #(.POR_WAIT_CYC(200), .PLL_CYC(PLL_CYC)) wmrs_host_end_i (
      .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .link(link), .i_boot(i_boot),
      .i_fw_valid(i_fw_valid), .i_fw_word(i_fw_word), .o_fw_ready(o_fw_ready),
      .o_link_ready(o_link_ready), .o_full_speed(h_full));

   wmrs_link_props wmrs_link_props_i (
      .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .sd_clk(link.sd_clk),
      .module_enable_n(link.module_enable_n), .cmd_h_oe(link.cmd_h_oe),
      .cmd(link.cmd), .dat_h_o(link.dat_h_o), .dat_h_oe(link.dat_h_oe),
      .dat_d_o(link.dat_d_o), .dat_d_oe(link.dat_d_oe));

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end

   // Time stamps of first edges, for ordering checks
   always @(posedge i_core_clk)
   begin
      cyc <= cyc + 1;
      if (fw_valid) rx_q.push_back(fw_word);
      if (!link.cmd && t_cmd == 0) t_cmd <= cyc;
      if (xtal_en && t_xtal == 0) t_xtal <= cyc;
      if (digital_phase_locked_loop_en && t_digital_phase_locked_loop == 0) t_digital_phase_locked_loop <= cyc;
      if (blk_rst_n && t_run == 0) t_run <= cyc;
      if (pll_valid && t_pll == 0) t_pll <= cyc;
      if (h_full && t_fs == 0) t_fs <= cyc;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic results();
      if (err_total == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wait_for(input string what, ref logic sig, input int lim);
      int n;
      n = 0;
      while (sig !== 1'b1 && n < lim)
      begin
         @(posedge i_core_clk);
         #1;
         n++;
      end
      if (n >= lim)
      begin
         err_total++;
         $display("Error %s expected 1 seen timeout", what);
         results();
      end
   endtask

   task automatic send(input logic [31:0] w);
      // An edge between words so valid is never set twice at once
      @(posedge i_core_clk);
      #1;
      i_fw_word  = w;
      i_fw_valid = 1'b1;
      wait_for("fw ready", o_fw_ready, 3000);
      @(posedge i_core_clk);
      #1;
      i_fw_valid = 1'b0;
   endtask

   // Full start-up through to a running module, then the PLL word
   task automatic boot_up(input logic [31:0] pll);
      t_cmd  = 0;
      t_xtal = 0;
      t_digital_phase_locked_loop = 0;
      t_run  = 0;
      t_pll  = 0;
      t_fs   = 0;
      wait_for("link ready", o_link_ready, 8000);
      check("power on", pwr_vec, 7'h7E);
      check("xtal after cmd", t_xtal > t_cmd, 1'b1);
      check("digital_phase_locked_loop after xtal", t_digital_phase_locked_loop > t_xtal, 1'b1);
      check("run after digital_phase_locked_loop", t_run > t_digital_phase_locked_loop, 1'b1);
      send(pll);
      wait_for("pll valid", pll_valid, 2000);
      check("pll setting", pll_setting, pll);
      wait_for("host full", h_full, 3000);
      check("pll settle", (t_fs - t_pll) >= PLL_CYC, 1'b1);
      wait_for("dev full", d_full, 200);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      i_rst_n     = 1'b0;
      i_boot      = 1'b0;
      i_fw_valid  = 1'b0;
      i_fw_word   = 32'h00000000;
      cyc         = 1;
      err_total   = 0;
      checks_done = 0;
      words       = '{32'h00000000, 32'hFFFFFFFF, 32'h80000001, 32'hA5C30F96};
      repeat (4) @(posedge i_core_clk);
      #1;
      i_rst_n = 1'b1;
      repeat (50) @(posedge i_core_clk);
      #1;
      check("held off", pwr_vec, 7'h01);
      boot_up(32'h1234ABCD);
      // Back-to-back words at full speed, boundary patterns
      rx_q.delete();
      foreach (words[i])
         send(words[i]);
      for (int n = 0; n < 2000 && rx_q.size() < 4; n++)
         @(posedge i_core_clk);
      #1;
      check("word count", rx_q.size(), 32'h4);
      foreach (words[i])
         if (i < rx_q.size())
            check("fw word", rx_q[i], words[i]);
      // Restart: enable pulsed low gives a fresh full reset
      i_boot = 1'b1;
      @(posedge i_core_clk);
      #1;
      i_boot = 1'b0;
      repeat (10) @(posedge i_core_clk);
      #1;
      check("reset again", pwr_vec, 7'h01);
      check("speed cleared", {d_full, pll_valid}, 2'h0);
      boot_up(32'h0F1E2D3C);
      results();
   end

endmodule
